// File: bench/dite_chk_assertions.sv
// Checker properties on the timing engine ports
`default_nettype none
`include "dite_defines.vh"
module dite_chk #(
  parameter NMOD = 2,
  parameter LINES = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic [NMOD*LINES-1:0] din_pins,
  input wire logic pause_dig,
  input wire logic [NMOD*LINES-1:0] din_filtered,
  input wire logic edge_change_event,
  input wire logic cd_sample_valid,
  input wire logic cd_fifo_push,
  input wire logic [LINES-1:0] dout,
  input wire logic dout_strobe,
  input wire logic underflow_q
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////
  // Shadow of control and serial mask; run is never cleared here,
  // which only narrows the software-write check
  logic [15:0] ctrl_q;
  logic [1:0] ser_q;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl_q <= 16'h0000;
      ser_q <= 2'h0;
    end else if (wr && addr == `DITE_A_CTRL) begin
      ctrl_q <= wdata[15:0];
    end else if (wr && addr == `DITE_A_CHSEL) begin
      ser_q <= wdata[1:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////
  // Idle software write to parallel modules only
  sequence s_sw_write;
    wr && addr == `DITE_A_SWOUT && !ctrl_q[0] && (wdata[9:8] & ser_q) == 2'h0;
  endsequence
  // Active-high digital pause held past the sync delay
  sequence s_paused;
    pause_dig [*4] ##1 (pause_dig && ctrl_q[12:11] == 2'h0 && !(wr && addr == `DITE_A_SWOUT));
  endsequence
  a_sw_write_out: assert property (s_sw_write |=> dout_strobe && dout == $past(wdata[LINES-1:0]))
    else $error("software write did not reach outputs");
  a_pause_no_strobe: assert property (s_paused |=> !dout_strobe)
    else $error("update while paused");
  a_dout_held: assert property (!dout_strobe |-> $stable(dout))
    else $error("output changed without update");
  a_underflow_sticky: assert property (underflow_q && !(wr && addr == `DITE_A_STATUS && wdata[0]) |=> underflow_q)
    else $error("underflow flag lost");
  a_filter_bypass: assert property ($past(rstn) && $past(rstn, 2) && !ctrl_q[1] && !$past(ctrl_q[1])
    |-> din_filtered == $past(din_pins, 2))
    else $error("unfiltered lines delayed");
  a_capture_one_path: assert property (!(cd_sample_valid && cd_fifo_push))
    else $error("sample sent both ways");
  a_capture_has_event: assert property (cd_sample_valid || cd_fifo_push |-> edge_change_event)
    else $error("capture without event");
  a_event_needs_cd: assert property (edge_change_event |-> ctrl_q[2] || $past(ctrl_q[2]))
    else $error("event with detection off");
endmodule // dite_chk
`default_nettype wire

// File: bench/dite_mod_model.sv
// Model of plug-in line modules, output module and capture FIFO
`default_nettype none
module dite_mod_model #(
  parameter CAP = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [15:0] lines,
  output logic [15:0] din_pins,
  input wire logic [7:0] dout,
  input wire logic dout_strobe,
  input wire logic cd_fifo_push,
  output logic cd_fifo_full
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got [0:63]; // Updates seen, in order
  int n; // Update count
  int held; // Capture entries, never drained
  assign din_pins = lines;
  assign cd_fifo_full = (held >= CAP);
  // Latch updates and fill capture store
  always @(posedge clk) begin
    if (!rstn) begin
      n <= 0;
      held <= 0;
    end else begin
      if (dout_strobe) begin
        got[n[5:0]] <= dout;
        n <= n + 1;
      end
      if (cd_fifo_push && held < CAP) begin
        held <= held + 1;
      end
    end
  end
endmodule // dite_mod_model
`default_nettype wire

// File: bench/tb.sv
// Self-checking bench for the digital I/O timing engine
`default_nettype none
`include "dite_defines.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rstn, wr, rd, trg, pause_dig, seen;
  logic [3:0] addr;
  logic [2:0] xdiv = 3'h0;
  logic [31:0] wdata, rdata, rv;
  logic [15:0] lines, din_pins, din_filtered, cd_sample;
  logic [7:0] dout;
  logic edge_change_event, cd_sample_valid, cd_fifo_push, cd_fifo_full, host_fetch_req, dout_strobe, underflow_q;
  int fail_count, samples_checked, base, k, r;
  typedef struct packed {logic [1:0] src; logic [3:0] cnt; logic ext; logic fall;} dite_row_t;
  // Start source, sample count, external clock, falling start edge
  dite_row_t rows [0:3] = '{'{2'h0, 4'h3, 1'b0, 1'b0}, '{2'h1, 4'h1, 1'b0, 1'b1}, '{2'h2, 4'h4, 1'b1, 1'b0},
    '{2'h3, 4'h2, 1'b0, 1'b0}};
  dite_engine dite_engine_i (.clk, .rstn, .ce(1'b1), .addr, .wdata, .wr, .rd, .rdata, .din_pins,
    .ext_sample_clk(xdiv[2]), .start_dig(trg), .start_ana(trg), .start_time(trg), .pause_dig, .pause_ana(1'b0),
    .din_filtered, .edge_change_event, .cd_sample, .cd_sample_valid, .cd_fifo_push, .cd_fifo_full,
    .host_fetch_req, .dout, .dout_strobe, .underflow_q);
  dite_mod_model #(.CAP(1)) dite_mod_model_i (.clk, .rstn, .lines, .din_pins, .dout, .dout_strobe,
    .cd_fifo_push, .cd_fifo_full);
  ////////////////////////////////////////////////////////////
  // 40 MHz clock; external sample clock is clk/8
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) xdiv <= xdiv + 3'h1;
  task automatic stop_test();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rreg(input logic [3:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  // Bounded watch: 0 direct sample, 1 buffered push, 2 update count
  task automatic wait_hi(input int sel, input int lim, input bit must);
    int i;
    seen = 1'b0;
    for (i = 0; i < lim && !seen; i++) begin
      cyc(1);
      case (sel)
        0: seen = cd_sample_valid;
        1: seen = cd_fifo_push;
        default: seen = (dite_mod_model_i.n >= base);
      endcase
    end
    if (must && !seen) begin
      fail_count++;
      stop_test();
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    rstn = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    trg = 1'b0;
    pause_dig = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    lines = 16'h0;
    fail_count = 0;
    samples_checked = 0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    rreg(`DITE_A_STATUS);
    chk(rv & 32'hF, 32'h0);
    rreg(4'hF);
    chk(rv, 32'h0);
    // Finite runs, one per start source
    for (r = 0; r < 4; r++) begin
      // Park the trigger on the side opposite to its start edge
      @(posedge clk) trg <= rows[r].fall;
      base = dite_mod_model_i.n + rows[r].cnt;
      wreg(`DITE_A_COUNT, {16'h0001, 12'h0, rows[r].cnt});
      for (k = 0; k < rows[r].cnt; k++) wreg(`DITE_A_FIFOW, {24'h0, r[3:0], k[3:0]});
      wreg(`DITE_A_CTRL, {21'h0, rows[r].fall, rows[r].src, rows[r].ext, 7'h41});
      cyc(3);
      @(posedge clk) trg <= !rows[r].fall;
      wait_hi(2, 300, 1'b1);
      cyc(20);
      chk(dite_mod_model_i.n, base);
      for (k = 0; k < rows[r].cnt; k++) chk(dite_mod_model_i.got[base - rows[r].cnt + k], {r[3:0], k[3:0]});
      rreg(`DITE_A_STATUS);
      chk(rv[2], 1'b1);
      rreg(`DITE_A_CTRL);
      chk(rv[0], 1'b0);
      wreg(`DITE_A_STATUS, 32'h4);
      @(posedge clk) trg <= 1'b0;
    end
    // Filter at 4 steps on both modules, then bypass
    wreg(`DITE_A_FILT, 32'h0003_0004);
    wreg(`DITE_A_CTRL, 32'h2);
    cyc(10);
    @(posedge clk) lines <= 16'hFFFF;
    @(posedge clk) lines <= 16'h0000;
    cyc(12);
    chk(din_filtered, 32'h0);
    @(posedge clk) lines <= 16'hFFFF;
    cyc(2);
    chk(din_filtered, 32'h0);
    cyc(20);
    chk(din_filtered, 32'hFFFF);
    wreg(`DITE_A_CTRL, 32'h0);
    @(posedge clk) lines <= 16'h5A5A;
    cyc(3);
    chk(din_filtered, 32'h5A5A);
    // Watch line 0, capture upper module only
    wreg(`DITE_A_CDRISE, 32'h1);
    wreg(`DITE_A_CDFALL, 32'h0);
    wreg(`DITE_A_CDCAP, 32'hFF00);
    wreg(`DITE_A_CTRL, 32'h4);
    @(posedge clk) lines <= 16'hA501;
    wait_hi(0, 10, 1'b1);
    chk(cd_sample, 32'hA500);
    chk(edge_change_event, 1'b1);
    @(posedge clk) lines <= 16'hA500;
    wait_hi(0, 10, 1'b0);
    chk(seen, 1'b0);
    wreg(`DITE_A_CDFALL, 32'h1);
    wreg(`DITE_A_CTRL, 32'hC);
    @(posedge clk) lines <= 16'hA501;
    wait_hi(1, 10, 1'b1);
    @(posedge clk) lines <= 16'hA500;
    wait_hi(1, 10, 1'b0);
    chk(seen, 1'b0);
    rreg(`DITE_A_STATUS);
    chk(rv[3], 1'b1);
    // Mixed serial and parallel timed task
    wreg(`DITE_A_CTRL, 32'h0);
    wreg(`DITE_A_STATUS, 32'hF);
    wreg(`DITE_A_CHSEL, 32'h0301);
    wreg(`DITE_A_CTRL, 32'h21);
    rreg(`DITE_A_STATUS);
    chk(rv[1], 1'b1);
    wreg(`DITE_A_CTRL, 32'h0);
    wreg(`DITE_A_STATUS, 32'hF);
    // Paused non-regeneration run with software writes
    @(posedge clk) pause_dig <= 1'b1;
    wreg(`DITE_A_CHSEL, 32'h0101);
    wreg(`DITE_A_CTRL, 32'h21);
    wreg(`DITE_A_SWOUT, 32'h15C);
    rreg(`DITE_A_STATUS);
    chk(rv[1], 1'b1);
    chk(dout, 32'h31);
    wreg(`DITE_A_SWOUT, 32'h2C3);
    cyc(1);
    chk(dout, 32'hC3);
    cyc(20);
    chk(underflow_q, 1'b0);
    chk(host_fetch_req, 1'b1);
    @(posedge clk) pause_dig <= 1'b0;
    cyc(20);
    chk(underflow_q, 1'b1);
    wreg(`DITE_A_CTRL, 32'h0);
    wreg(`DITE_A_STATUS, 32'h1);
    cyc(1);
    chk(underflow_q, 1'b0);
    chk(host_fetch_req, 1'b0);
    wreg(`DITE_A_SWOUT, 32'h2A5);
    cyc(1);
    chk(dout, 32'hA5);
    // Onboard replay of two words; a write while running must not join
    wreg(`DITE_A_CTRL, 32'h10);
    base = dite_mod_model_i.n + 4;
    wreg(`DITE_A_FIFOW, 32'hD1);
    wreg(`DITE_A_FIFOW, 32'hD2);
    wreg(`DITE_A_CTRL, 32'h11);
    cyc(4);
    wreg(`DITE_A_FIFOW, 32'hEE);
    wait_hi(2, 100, 1'b1);
    for (k = 0; k < 4; k++) chk(dite_mod_model_i.got[base - 4 + k], k[0] ? 32'hD2 : 32'hD1);
    chk(host_fetch_req, 1'b0);
    wreg(`DITE_A_CTRL, 32'h0);
    stop_test();
  end
endmodule // tb
bind dite_engine dite_chk #(.NMOD(NMOD), .LINES(LINES)) dite_chk_i (.clk, .rstn, .addr, .wdata, .wr, .din_pins,
  .pause_dig, .din_filtered, .edge_change_event, .cd_sample_valid, .cd_fifo_push, .dout, .dout_strobe, .underflow_q);
`default_nettype wire

// File: rtl/dite_defines.vh
// Constants for the digital I/O timing engine
`ifndef DITE_DEFINES_VH
`define DITE_DEFINES_VH
// Register word addresses
`define DITE_A_CTRL 4'h0
`define DITE_A_FILT 4'h1
`define DITE_A_CDRISE 4'h2
`define DITE_A_CDFALL 4'h3
`define DITE_A_CDCAP 4'h4
`define DITE_A_COUNT 4'h5
`define DITE_A_FIFOW 4'h6
`define DITE_A_SWOUT 4'h7
`define DITE_A_STATUS 4'h8
`define DITE_A_CDDATA 4'h9
`define DITE_A_CHSEL 4'hA
// Control fields
`define DITE_C_RUN 0
`define DITE_C_FILT_EN 1
`define DITE_C_CD_EN 2
`define DITE_C_CD_BUF 3
`define DITE_C_MODE_LO 4
`define DITE_C_MODE_HI 5
`define DITE_C_FINITE 6
`define DITE_C_EXTCLK 7
`define DITE_C_STSRC_LO 8
`define DITE_C_STSRC_HI 9
`define DITE_C_STEDGE 10
`define DITE_C_PSRC 11
`define DITE_C_PPOL 12
`define DITE_C_SERIAL 13
`define DITE_C_CLR 14
// Continuous generation modes
`define DITE_M_REGEN 2'h0
`define DITE_M_ONBOARD 2'h1
`define DITE_M_NOREGEN 2'h2
// Start trigger sources
`define DITE_S_SOFT 2'h0
`define DITE_S_DIG 2'h1
`define DITE_S_ANA 2'h2
`define DITE_S_TIME 2'h3
// Filter step and clock period, in picoseconds
`define DITE_STEP_PS 25000
`define DITE_CLK_PS 25000
`define DITE_STEP_CYC ((`DITE_STEP_PS + `DITE_CLK_PS - 1) / `DITE_CLK_PS)
// Field offsets inside multi-field words
`define DITE_SW_MASK_LO 8
`define DITE_CH_TIMED_LO 8
`define DITE_FILT_SEL_LO 16
`define DITE_PERIOD_LO 16
// Status bits
`define DITE_ST_UNDER 0
`define DITE_ST_REFUSE 1
`define DITE_ST_DONE 2
`define DITE_ST_CDOVF 3
`endif

// File: rtl/dite_engine.v
// Digital I/O timing engine: input filter, change detection, timed output
// Functional notes
// - One filter setting per module, all lines
// - Enabled filter samples on derived filter clock
// - Minimum pass width set in 25 ns steps
// - Pulses under half width always rejected
// - Change passes after two consecutive equal samples
// - Per-line rise/fall watch captures the cap_q lines
// - Watch set and capture set independent
// - Edge change event pulse, routable out
// - Buffered capture via FIFO, else direct
// - Timed output always through onboard FIFO
// - Each software command writes one value
// - Serial module in timed task refuses software
// - Timed task never mixes parallel and serial
// - Sample clock internal or external source
// - Host buffer fills FIFO, outputs from FIFO
// - Finite mode stops after exact count
// - Regeneration refetches host buffer repeatedly
// - Onboard regeneration replays FIFO, refuses data
// - Non-regeneration flags underflow when empty
// - Start and pause triggers, selectable sources
// - Pause takes effect from next sample
//
// Strobed register access and the register offsets were left to the implementer.
`default_nettype none
`include "dite_defines.vh"
module dite_engine #(
  parameter NMOD = 2, // Input modules
  parameter LINES = 8, // Lines per module
  parameter DEPTH_LOG2 = 6, // Output FIFO depth, log2
  parameter CNT_W = 16 // Width of filter and sample counters
) (
  input wire clk,
  input wire rstn,
  input wire ce,
  input wire [3:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata,
  input wire [NMOD*LINES-1:0] din_pins,
  input wire ext_sample_clk,
  input wire start_dig,
  input wire start_ana,
  input wire start_time,
  input wire pause_dig,
  input wire pause_ana,
  output wire [NMOD*LINES-1:0] din_filtered,
  output reg edge_change_event,
  output reg [NMOD*LINES-1:0] cd_sample,
  output reg cd_sample_valid,
  output reg cd_fifo_push,
  input wire cd_fifo_full,
  output reg host_fetch_req,
  output reg [LINES-1:0] dout,
  output reg dout_strobe,
  output reg underflow_q
);
  localparam NL = NMOD*LINES;
  localparam DEPTH = 1 << DEPTH_LOG2;
  localparam integer STEP_I = `DITE_STEP_CYC; // Clock cycles per filter step
  localparam [CNT_W-1:0] STEP = STEP_I[CNT_W-1:0];
  // Generation states, one-hot
  localparam [2:0] S_IDLE = 3'b001;
  localparam [2:0] S_ARM = 3'b010;
  localparam [2:0] S_RUN = 3'b100;

  ////////////////////////////////////////////////////////////////////////
  // Registers
  reg [15:0] ctrl_q; // Control word
  reg [NMOD*CNT_W-1:0] filt_q; // Per-module min width in steps
  reg [NL-1:0] rise_q; // Lines watched for rising edges
  reg [NL-1:0] fall_q; // Lines watched for falling edges
  reg [NL-1:0] cap_q; // Lines captured
  reg [CNT_W-1:0] count_q; // Finite sample count
  reg [CNT_W-1:0] period_q; // Internal sample clock period
  reg [NMOD-1:0] mod_serial_q; // Module is serial kind
  reg [NMOD-1:0] mod_timed_q; // Module has channels in the timed task
  reg refuse_q; // Sticky refused-command flag
  reg done_q; // Sticky finite-done flag
  reg cd_ovf_q; // Sticky capture overflow
  reg [2:0] st_q; // Generation state
  reg [DEPTH_LOG2:0] wp_q, rp_q, fill_q; // FIFO pointers and onboard fill
  reg [LINES-1:0] mem [0:DEPTH-1]; // Output FIFO storage
  reg [CNT_W-1:0] done_cnt_q; // Samples issued
  reg [CNT_W-1:0] div_q; // Internal clock divider
  reg [2:0] ext_s; // External clock sync plus history
  reg [1:0] stt_s, pa_s, pd_s, sd_s, sa_s; // Trigger synchronisers
  reg stt_h, sd_h, sa_h; // Start trigger history

  wire run = ctrl_q[`DITE_C_RUN];
  wire [1:0] mode = ctrl_q[`DITE_C_MODE_HI:`DITE_C_MODE_LO];
  wire [1:0] stsrc = ctrl_q[`DITE_C_STSRC_HI:`DITE_C_STSRC_LO];
  wire fifo_empty = (wp_q == rp_q);
  wire fifo_full = (wp_q[DEPTH_LOG2] != rp_q[DEPTH_LOG2]) && (wp_q[DEPTH_LOG2-1:0] == rp_q[DEPTH_LOG2-1:0]);
  // Timed task mixing module kinds is illegal
  // kind mix check
  wire mix_bad = |(mod_timed_q & mod_serial_q) && |(mod_timed_q & ~mod_serial_q);

  ////////////////////////////////////////////////////////////////////////
  // Input filter, one clock divider per module shared by all its lines
  wire [NL-1:0] din_s1_w;
  genvar m, l;
  generate
    for (m = 0; m < NMOD; m = m + 1) begin : g_mod
      reg [LINES-1:0] s1, s2; // Pin synchroniser
      reg [CNT_W-1:0] fdiv_q; // Filter clock divider
      reg [LINES-1:0] out_q; // Debounced value
      reg [LINES*CNT_W-1:0] run_q; // Per-line agreeing-sample counts
      // Width N halves into two filter ticks per minimum width
      wire [CNT_W-1:0] half = (filt_q[m*CNT_W +: CNT_W] >> 1);
      wire ftick = (fdiv_q == 0);
      always @(posedge clk) begin
        if (!rstn) begin
          s1 <= {LINES{1'b0}};
          s2 <= {LINES{1'b0}};
        end else if (ce) begin
          s1 <= din_pins[m*LINES +: LINES];
          s2 <= s1;
        end
      end
      // Filter clock from chassis clock, period = half width in steps
      // derived filter clock
      always @(posedge clk) begin
        if (!rstn) begin
          fdiv_q <= {CNT_W{1'b0}};
        end else if (ce) begin
          if (ftick) begin
            fdiv_q <= (half == 0) ? {CNT_W{1'b0}} : (half * STEP) - 1'b1;
          end else begin
            fdiv_q <= fdiv_q - 1'b1;
          end
        end
      end
      for (l = 0; l < LINES; l = l + 1) begin : g_line
        // two ticks needed, short pulses die
        always @(posedge clk) begin
          if (!rstn) begin
            run_q[l*CNT_W +: CNT_W] <= {CNT_W{1'b0}};
            out_q[l] <= 1'b0;
          end else if (ce && ftick) begin
            if (s2[l] == out_q[l]) begin
              run_q[l*CNT_W +: CNT_W] <= {CNT_W{1'b0}};
            end else if (run_q[l*CNT_W +: CNT_W] >= 1) begin
              out_q[l] <= s2[l];
              run_q[l*CNT_W +: CNT_W] <= {CNT_W{1'b0}};
            end else begin
              run_q[l*CNT_W +: CNT_W] <= run_q[l*CNT_W +: CNT_W] + 1'b1;
            end
          end
        end
      end
      assign din_filtered[m*LINES +: LINES] = ctrl_q[`DITE_C_FILT_EN] ? out_q : s2;
      assign din_s1_w[m*LINES +: LINES] = s2;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Change detection on filtered lines
  reg [NL-1:0] prev_q; // Previous filtered value
  wire [NL-1:0] hit = (rise_q & din_filtered & ~prev_q) | (fall_q & ~din_filtered & prev_q);
  always @(posedge clk) begin
    if (!rstn) begin
      prev_q <= {NL{1'b0}};
      edge_change_event <= 1'b0;
      cd_sample <= {NL{1'b0}};
      cd_sample_valid <= 1'b0;
      cd_fifo_push <= 1'b0;
      cd_ovf_q <= 1'b0;
    end else if (ce) begin
      prev_q <= din_filtered;
      edge_change_event <= ctrl_q[`DITE_C_CD_EN] && |hit;
      cd_sample_valid <= 1'b0;
      cd_fifo_push <= 1'b0;
      // Clear first, so an overflow in the same cycle still wins
      if (wr && addr == `DITE_A_STATUS && wdata[`DITE_ST_CDOVF]) begin
        cd_ovf_q <= 1'b0;
      end
      if (ctrl_q[`DITE_C_CD_EN] && |hit) begin
        cd_sample <= din_filtered & cap_q;
        if (ctrl_q[`DITE_C_CD_BUF]) begin
          cd_fifo_push <= ~cd_fifo_full;
          if (cd_fifo_full) begin
            cd_ovf_q <= 1'b1;
          end
        end else begin
          cd_sample_valid <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Trigger and sample clock synchronisers
  always @(posedge clk) begin
    if (!rstn) begin
      ext_s <= 3'h0;
      stt_s <= 2'h0;
      pa_s <= 2'h0;
      pd_s <= 2'h0;
      sd_s <= 2'h0;
      sa_s <= 2'h0;
      stt_h <= 1'b0;
      sd_h <= 1'b0;
      sa_h <= 1'b0;
    end else if (ce) begin
      ext_s <= {ext_s[1:0], ext_sample_clk};
      stt_s <= {stt_s[0], start_time};
      pa_s <= {pa_s[0], pause_ana};
      pd_s <= {pd_s[0], pause_dig};
      sd_s <= {sd_s[0], start_dig};
      sa_s <= {sa_s[0], start_ana};
      stt_h <= stt_s[1];
      sd_h <= sd_s[1];
      sa_h <= sa_s[1];
    end
  end
  // Selected start edge; time source is a rising level change
  // start source and edge select
  reg start_ev;
  always @* begin
    case (stsrc)
      `DITE_S_DIG: start_ev = ctrl_q[`DITE_C_STEDGE] ? (sd_h & ~sd_s[1]) : (~sd_h & sd_s[1]);
      `DITE_S_ANA: start_ev = ctrl_q[`DITE_C_STEDGE] ? (sa_h & ~sa_s[1]) : (~sa_h & sa_s[1]);
      `DITE_S_TIME: start_ev = ~stt_h & stt_s[1];
      default: start_ev = 1'b1; // Software start fires when armed
    endcase
  end
  wire pause_raw = ctrl_q[`DITE_C_PSRC] ? pa_s[1] : pd_s[1];
  wire pause = pause_raw ^ ctrl_q[`DITE_C_PPOL];
  wire sclk = ctrl_q[`DITE_C_EXTCLK] ? (ext_s[1] & ~ext_s[2]) : (div_q == 0);

  ////////////////////////////////////////////////////////////////////////
  // Generation state machine and output FIFO
  wire host_wr = wr && addr == `DITE_A_FIFOW;
  // onboard replay refuses new data once running
  wire load_ok = host_wr && !fifo_full && !(mode == `DITE_M_ONBOARD && st_q == S_RUN && !ctrl_q[`DITE_C_FINITE]);
  // pause sampled only at sample boundaries
  wire take = (st_q == S_RUN) && sclk && !pause;
  wire pop = take && !fifo_empty;
  // software refused on timed serial module
  wire sw_bad = |(mod_serial_q & mod_timed_q & wdata[`DITE_SW_MASK_LO +: NMOD]) && (st_q != S_IDLE);
  always @(posedge clk) begin
    if (!rstn) begin
      st_q <= S_IDLE;
      wp_q <= {(DEPTH_LOG2+1){1'b0}};
      rp_q <= {(DEPTH_LOG2+1){1'b0}};
      fill_q <= {(DEPTH_LOG2+1){1'b0}};
      done_cnt_q <= {CNT_W{1'b0}};
      div_q <= {CNT_W{1'b0}};
      dout <= {LINES{1'b0}};
      dout_strobe <= 1'b0;
      host_fetch_req <= 1'b0;
      underflow_q <= 1'b0;
      refuse_q <= 1'b0;
      done_q <= 1'b0;
    end else if (ce) begin
      dout_strobe <= 1'b0;
      div_q <= (st_q != S_RUN || div_q == 0) ? period_q : div_q - 1'b1;
      if (load_ok) begin
        mem[wp_q[DEPTH_LOG2-1:0]] <= wdata[LINES-1:0];
        wp_q <= wp_q + 1'b1;
        // Onboard image restarts when its first word lands in an empty FIFO
        if (mode == `DITE_M_ONBOARD) begin
          fill_q <= fifo_empty ? {{DEPTH_LOG2{1'b0}}, 1'b1} : fill_q + 1'b1;
        end
      end
      // request more host data in streaming modes
      host_fetch_req <= (st_q == S_RUN) && (mode != `DITE_M_ONBOARD) && !fifo_full;
      if (wr && addr == `DITE_A_SWOUT) begin
        if (sw_bad) begin
          refuse_q <= 1'b1;
        end else begin
          dout <= wdata[LINES-1:0];
          dout_strobe <= 1'b1;
        end
      end
      if (wr && addr == `DITE_A_STATUS) begin
        underflow_q <= underflow_q & ~wdata[`DITE_ST_UNDER];
        refuse_q <= refuse_q & ~wdata[`DITE_ST_REFUSE];
        done_q <= done_q & ~wdata[`DITE_ST_DONE];
      end
      case (st_q)
        S_IDLE: begin
          done_cnt_q <= {CNT_W{1'b0}};
          if (run && !mix_bad) begin
            st_q <= S_ARM;
          end else if (run) begin
            refuse_q <= 1'b1;
          end
        end
        S_ARM: begin
          if (!run) begin
            st_q <= S_IDLE;
          end else if (start_ev) begin
            st_q <= S_RUN;
          end
        end
        S_RUN: begin
          if (!run) begin
            st_q <= S_IDLE;
          end else if (take) begin
            if (fifo_empty) begin
              underflow_q <= 1'b1;
            end else begin
              dout <= mem[rp_q[DEPTH_LOG2-1:0]];
              dout_strobe <= 1'b1;
              done_cnt_q <= done_cnt_q + 1'b1;
              if (mode == `DITE_M_ONBOARD && !ctrl_q[`DITE_C_FINITE] && rp_q + 1'b1 == wp_q) begin
                rp_q <= wp_q - fill_q;
              end else begin
                rp_q <= rp_q + 1'b1;
              end
              if (ctrl_q[`DITE_C_FINITE] && done_cnt_q + 1'b1 == count_q) begin
                st_q <= S_IDLE;
                done_q <= 1'b1;
              end
            end
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register writes
  integer i;
  always @(posedge clk) begin
    if (!rstn) begin
      ctrl_q <= 16'h0000;
      filt_q <= {(NMOD*CNT_W){1'b0}};
      rise_q <= {NL{1'b0}};
      fall_q <= {NL{1'b0}};
      cap_q <= {NL{1'b0}};
      count_q <= {CNT_W{1'b0}};
      period_q <= {CNT_W{1'b0}};
      mod_serial_q <= {NMOD{1'b0}};
      mod_timed_q <= {NMOD{1'b0}};
    end else if (ce) begin
      if (st_q == S_RUN && ctrl_q[`DITE_C_FINITE] && take && !fifo_empty && done_cnt_q + 1'b1 == count_q) begin
        ctrl_q[`DITE_C_RUN] <= 1'b0; // Finite run self-clears
      end
      if (wr) begin
        case (addr)
          `DITE_A_CTRL: ctrl_q <= wdata[15:0];
          `DITE_A_FILT: begin
            for (i = 0; i < NMOD; i = i + 1) begin
              if (wdata[`DITE_FILT_SEL_LO + i]) begin
                filt_q[i*CNT_W +: CNT_W] <= wdata[CNT_W-1:0];
              end
            end
          end
          `DITE_A_CDRISE: rise_q <= wdata[NL-1:0];
          `DITE_A_CDFALL: fall_q <= wdata[NL-1:0];
          `DITE_A_CDCAP: cap_q <= wdata[NL-1:0];
          `DITE_A_COUNT: begin
            count_q <= wdata[CNT_W-1:0];
            period_q <= wdata[`DITE_PERIOD_LO +: CNT_W];
          end
          `DITE_A_CHSEL: begin
            mod_serial_q <= wdata[NMOD-1:0];
            mod_timed_q <= wdata[`DITE_CH_TIMED_LO +: NMOD];
          end
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe
  always @(posedge clk) begin
    if (!rstn) begin
      rdata <= 32'h00000000;
    end else if (ce) begin
      rdata <= 32'h00000000;
      if (rd) begin
        case (addr)
          `DITE_A_CTRL: rdata <= {16'h0000, ctrl_q};
          `DITE_A_CDRISE: rdata <= {{(32-NL){1'b0}}, rise_q};
          `DITE_A_CDFALL: rdata <= {{(32-NL){1'b0}}, fall_q};
          `DITE_A_CDCAP: rdata <= {{(32-NL){1'b0}}, cap_q};
          `DITE_A_STATUS: rdata <= {16'h0000, done_cnt_q[7:0], 1'b0, st_q,
            cd_ovf_q, done_q, refuse_q, underflow_q};
          `DITE_A_CDDATA: rdata <= {{(32-NL){1'b0}}, din_s1_w};
          default: rdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // dite_engine
`default_nettype wire
